// *** include/focc_pkg.sv ***
// Purpose: shared constants and types of the frequency offset compensation configuration block
// Assumes: one 8-bit configuration register reached over a plain address/strobe register port
// Notes: gain codes are expressed in units of K/2 so that K/2 itself is an integer
package focc_pkg;

  // register map
  localparam logic [5:0] FOCC_CFG_ADDR = 6'h19;
  localparam logic [7:0] FOCC_CFG_RESET = 8'h36;
  localparam logic [7:0] FOCC_RD_UNMAPPED = 8'h00;

  // field positions inside freq_offset_comp_cfg
  localparam int FOCC_GATE_BIT = 5;
  localparam int FOCC_PRE_K_LSB = 3;
  localparam int FOCC_POST_K_BIT = 2;
  localparam int FOCC_LIMIT_LSB = 0;

  // gain in units of K/2
  localparam logic [3:0] FOCC_GAIN_HALF_K = 4'h1;
  localparam logic [3:0] FOCC_GAIN_RESET = 4'h6;

  // saturation limit codes
  localparam logic [1:0] FOCC_LIMIT_OFF = 2'h0;
  localparam logic [1:0] FOCC_LIMIT_DIV8 = 2'h1;
  localparam logic [1:0] FOCC_LIMIT_DIV4 = 2'h2;
  localparam logic [1:0] FOCC_LIMIT_DIV2 = 2'h3;

  typedef struct packed {
    logic loop_freeze_until_carrier;
    logic [1:0] pre_sync_loop_gain;
    logic post_sync_loop_gain;
    logic [1:0] offset_saturation_limit;
  } focc_cfg_t;

  // register port request
  typedef struct packed {
    logic [5:0] addr;
    logic wr_en;
    logic rd_en;
    logic [7:0] wr_data;
  } focc_reg_req_t;

  typedef enum logic [0:0] {
    FOCC_ST_FROZEN,
    FOCC_ST_TRACKING
  } focc_loop_state_t;

endpackage : focc_pkg

// *** logic/focc_offset_clamp.sv ***
// Purpose: saturate the compensated frequency offset to a fraction of channel filter bandwidth
// Assumes: offset estimate and bandwidth share one scale; bandwidth is unsigned
// Notes: output holds its last value while the loop is frozen
`timescale 1ns/100ps
`default_nettype none
module focc_offset_clamp
#(
  parameter int W = 16
)
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // control
  input wire logic hold_in,
  input wire logic [1:0] limit_code_in,
  // data
  input wire logic signed [W-1:0] offset_est_in,
  input wire logic [W-1:0] channel_filter_bandwidth_in,
  output logic signed [W-1:0] offset_comp_out
);
  import focc_pkg::*;

  logic signed [W-1:0] nxt_offset_comp;
  logic [W-1:0] lim_u;
  logic signed [W:0] pos_lim;
  logic signed [W:0] neg_lim;
  logic signed [W:0] off_ext;

  always_comb
  begin
    case (limit_code_in)
      FOCC_LIMIT_DIV8: lim_u = channel_filter_bandwidth_in >> 3;
      FOCC_LIMIT_DIV4: lim_u = channel_filter_bandwidth_in >> 2;
      FOCC_LIMIT_DIV2: lim_u = channel_filter_bandwidth_in >> 1;
      default: lim_u = '0;
    endcase
    pos_lim = $signed({1'b0, lim_u});
    neg_lim = -pos_lim;
    off_ext = {offset_est_in[W-1], offset_est_in};
    if (hold_in)
      nxt_offset_comp = offset_comp_out;
    else if (limit_code_in == FOCC_LIMIT_OFF)
      nxt_offset_comp = '0;
    else if (off_ext > pos_lim)
      nxt_offset_comp = pos_lim[W-1:0];
    else if (off_ext < neg_lim)
      nxt_offset_comp = neg_lim[W-1:0];
    else
      nxt_offset_comp = offset_est_in;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      offset_comp_out <= '0;
    else
      offset_comp_out <= nxt_offset_comp;
  end

endmodule : focc_offset_clamp
`default_nettype wire

// *** logic/focc_top.sv ***
// Purpose: configuration register and loop control of frequency offset compensation
// Assumes: sync detect, carrier sense and restart come from demodulator logic on sys_clk_in
// Notes: all outputs registered; one cycle of latency from the demodulator inputs
//   freeze, gain and clamp hold all use next-state values so they change on one edge
//   the saturation code is not checked against the modulation format in use
`timescale 1ns/100ps
`default_nettype none
module focc_top
#(
  parameter int OFFSET_W = 16
)
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // register port
  input wire focc_pkg::focc_reg_req_t reg_req_in,
  output logic [7:0] reg_rd_data_out,
  output logic reg_rd_valid_out,
  // demodulator status
  input wire logic rx_restart_in,
  input wire logic sync_detect_in,
  input wire logic carrier_sense_in,
  // loop control
  output logic offset_loop_freeze_out,
  output logic clock_recovery_freeze_out,
  output logic [3:0] offset_loop_gain_out,
  output focc_pkg::focc_cfg_t cfg_out,
  // offset data path
  input wire logic signed [OFFSET_W-1:0] offset_est_in,
  input wire logic [OFFSET_W-1:0] channel_filter_bandwidth_in,
  output logic signed [OFFSET_W-1:0] offset_comp_out
);
  import focc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration register

  focc_cfg_t cfg_ff;
  focc_cfg_t nxt_cfg;
  logic hit;

  always_comb
  begin
    hit = (reg_req_in.addr == FOCC_CFG_ADDR);
    nxt_cfg = cfg_ff;
    if (reg_req_in.wr_en && hit)
    begin
      // bits 7:6 are simply not stored
      nxt_cfg.loop_freeze_until_carrier = reg_req_in.wr_data[FOCC_GATE_BIT];
      nxt_cfg.pre_sync_loop_gain = reg_req_in.wr_data[FOCC_PRE_K_LSB +: 2];
      nxt_cfg.post_sync_loop_gain = reg_req_in.wr_data[FOCC_POST_K_BIT];
      nxt_cfg.offset_saturation_limit = reg_req_in.wr_data[FOCC_LIMIT_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      cfg_ff <= focc_cfg_t'(FOCC_CFG_RESET[5:0]);
    else
      cfg_ff <= nxt_cfg;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port

  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;
  logic rd_valid_ff;
  logic nxt_rd_valid;

  always_comb
  begin
    nxt_rd_valid = reg_req_in.rd_en;
    nxt_rd_data = rd_data_ff;
    // a read in the same cycle as a write returns the old contents
    if (reg_req_in.rd_en)
    begin
      if (hit)
        nxt_rd_data = {2'h0, cfg_ff};
      else
        nxt_rd_data = FOCC_RD_UNMAPPED;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive phase: carrier and sync tracking

  focc_loop_state_t state_ff;
  focc_loop_state_t nxt_state;
  logic sync_seen_ff;
  logic nxt_sync_seen;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      FOCC_ST_FROZEN:
      begin
        if (carrier_sense_in)
          nxt_state = FOCC_ST_TRACKING;
      end
      FOCC_ST_TRACKING:
      begin
        // restart only re-arms the freeze once carrier sense has dropped
        if (rx_restart_in && !carrier_sense_in)
          nxt_state = FOCC_ST_FROZEN;
      end
      default:
      begin
        nxt_state = FOCC_ST_FROZEN;
      end
    endcase
    // a sync arriving with a restart still counts: set wins over clear
    nxt_sync_seen = sync_detect_in | (sync_seen_ff & ~rx_restart_in);
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_ff <= FOCC_ST_FROZEN;
      sync_seen_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      sync_seen_ff <= nxt_sync_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // loop freeze

  logic freeze_ff;
  logic nxt_freeze;

  always_comb
  begin
    // gating off releases the loops at once, even mid-reception
    nxt_freeze = 1'b0;
    if (cfg_ff.loop_freeze_until_carrier && (nxt_state == FOCC_ST_FROZEN))
      nxt_freeze = 1'b1;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      freeze_ff <= 1'b1;
    else
      freeze_ff <= nxt_freeze;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // loop gain in units of K/2

  logic [3:0] pre_gain;
  logic [3:0] gain_ff;
  logic [3:0] nxt_gain;

  always_comb
  begin
    // codes 0..3 map to K..4K, which is 2..8 in half-K units
    pre_gain = {1'b0, cfg_ff.pre_sync_loop_gain, 1'b0} + 4'h2;
    // uses the next sync view so gain and freeze move on the same edge
    if (nxt_sync_seen && cfg_ff.post_sync_loop_gain)
      nxt_gain = FOCC_GAIN_HALF_K;
    else
      nxt_gain = pre_gain;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      gain_ff <= FOCC_GAIN_RESET;
    else
      gain_ff <= nxt_gain;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // offset saturation; software must pick code 0 for ASK/OOK, nothing here enforces it

  focc_offset_clamp
  #(
    .W(OFFSET_W)
  )
  u_clamp
  (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .hold_in(nxt_freeze),
    .limit_code_in(cfg_ff.offset_saturation_limit),
    .offset_est_in(offset_est_in),
    .channel_filter_bandwidth_in(channel_filter_bandwidth_in),
    .offset_comp_out(offset_comp_out)
  );

  assign reg_rd_data_out = rd_data_ff;
  assign reg_rd_valid_out = rd_valid_ff;
  assign offset_loop_freeze_out = freeze_ff;
  assign clock_recovery_freeze_out = freeze_ff;
  assign offset_loop_gain_out = gain_ff;
  assign cfg_out = cfg_ff;

endmodule : focc_top
`default_nettype wire

// *** test/focc_chk.sv ***
// Purpose: port checks of focc_top
// Assumes: one clock domain, async high reset
// Notes: bound into every focc_top
`timescale 1ns/100ps
`default_nettype none
module focc_chk
import focc_pkg::*;
#(
  parameter int OFFSET_W = 16
)
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // register port
  input wire focc_pkg::focc_reg_req_t reg_req_in,
  input wire logic [7:0] reg_rd_data_out,
  input wire logic reg_rd_valid_out,
  // demodulator and loop
  input wire logic rx_restart_in,
  input wire logic sync_detect_in,
  input wire logic carrier_sense_in,
  input wire logic offset_loop_freeze_out,
  input wire logic clock_recovery_freeze_out,
  input wire logic [3:0] offset_loop_gain_out,
  input wire focc_pkg::focc_cfg_t cfg_out,
  input wire logic signed [OFFSET_W-1:0] offset_comp_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  wire logic hit = reg_req_in.addr == FOCC_CFG_ADDR;
  a_freeze_both: assert property (clock_recovery_freeze_out == offset_loop_freeze_out)
    else $error("freeze outputs differ");
  a_ungated_runs: assert property (!cfg_out.loop_freeze_until_carrier |=> !offset_loop_freeze_out)
    else $error("frozen with gate clear");
  a_carrier_thaws: assert property (carrier_sense_in |=> !offset_loop_freeze_out)
    else $error("frozen after carrier sense");
  a_frozen_holds: assert property (offset_loop_freeze_out |-> $stable(offset_comp_out))
    else $error("offset moved while frozen");
  a_read_data: assert property (reg_req_in.rd_en && hit |=> reg_rd_data_out == {2'h0, $past(cfg_out)})
    else $error("read data wrong");
  a_unmapped_zero: assert property (reg_req_in.rd_en && !hit |=> reg_rd_data_out == 8'h00)
    else $error("unmapped read not zero");
  a_post_half: assert property (sync_detect_in && cfg_out.post_sync_loop_gain |=> offset_loop_gain_out == 4'h1)
    else $error("post sync gain not half");
  a_pre_gain: assert property (!cfg_out.post_sync_loop_gain |=>
    offset_loop_gain_out == 4'(2 * ($past(cfg_out.pre_sync_loop_gain) + 1)))
    else $error("pre sync gain wrong");
  a_restart_freezes: assert property (
    cfg_out.loop_freeze_until_carrier && rx_restart_in && !carrier_sense_in |=> offset_loop_freeze_out)
    else $error("restart did not freeze the loops");
  a_read_valid: assert property (reg_rd_valid_out == $past(reg_req_in.rd_en))
    else $error("read valid wrong");
  a_limit_off: assert property (cfg_out.offset_saturation_limit == 2'h0 |=>
    offset_loop_freeze_out || offset_comp_out == '0)
    else $error("offset passed with limit off");
endmodule : focc_chk
bind focc_top focc_chk #(.OFFSET_W(OFFSET_W)) chk_u (.sys_clk_in, .reset_in, .reg_req_in, .reg_rd_data_out,
  .reg_rd_valid_out, .rx_restart_in,
  .sync_detect_in, .carrier_sense_in, .offset_loop_freeze_out, .clock_recovery_freeze_out,
  .offset_loop_gain_out, .cfg_out, .offset_comp_out);
`default_nettype wire

// *** test/tb_top.sv ***
// Purpose: self-checking bench of focc_top
// Assumes: 20 MHz clock, inputs driven at falling edge
// Notes: random data from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import focc_pkg::*;
  logic clk = 0, rst = 1, rs = 0, sy = 0, cs = 0, vld, frz, crf;
  focc_reg_req_t req = '0;
  logic [7:0] rdd, d;
  logic [3:0] gain;
  focc_cfg_t cfg;
  logic signed [15:0] est = 0, comp, h;
  logic [15:0] bw = 0;
  int num_errors = 0, samples_checked = 0, seed = 69;
  always #25 clk = ~clk;
  focc_top dut_u (.sys_clk_in(clk), .reset_in(rst), .reg_req_in(req), .reg_rd_data_out(rdd),
    .reg_rd_valid_out(vld), .rx_restart_in(rs), .sync_detect_in(sy), .carrier_sense_in(cs),
    .offset_loop_freeze_out(frz), .clock_recovery_freeze_out(crf), .offset_loop_gain_out(gain),
    .cfg_out(cfg), .offset_est_in(est), .channel_filter_bandwidth_in(bw), .offset_comp_out(comp));
  ////////////////////////////////////////////////////////////////
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // strobes stay up until the next request replaces them; repeats are harmless
  task automatic wr(logic [5:0] a, logic [7:0] v);
    req = {a, 2'h2, v};
    tick(1);
  endtask : wr
  task automatic rd(logic [5:0] a, logic [7:0] e);
    req = {a, 2'h1, 8'h00};
    tick(1);
    chk(vld, 1);
    chk(rdd, e);
  endtask : rd
  function automatic logic [3:0] exp_gain(logic [7:0] c, logic s);
    return (s && c[2]) ? 4'h1 : 4'(2 * (c[4:3] + 1));
  endfunction : exp_gain
  function automatic logic [15:0] exp_clamp(logic signed [15:0] e, logic [15:0] b, logic [1:0] c);
    logic signed [15:0] l;
    l = (c == 2'h0) ? 16'sh0 : $signed(b >> (4 - c));
    return e > l ? l : (e < -l ? -l : e);
  endfunction : exp_clamp
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////
  initial
  begin
    tick(5);
    rst = 0;
    rd(6'h19, 8'h36);
    chk(gain, 4'h6);
    chk(frz, 1);
    chk(cfg, 16'h0036);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      d = $random(seed);
      d[4:3] = i[1:0];
      wr(6'h19, d);
      wr(6'h18, ~d);
      chk(vld, 0);
      rd(6'h19, {2'h0, d[5:0]});
      rd(6'h1a, 8'h00);
      chk(gain, exp_gain(d, 0));
      chk(cfg, d[5:0]);
    end
    $display("test register done");
    for (int c = 0; c < 4; c++)
    begin
      wr(6'h19, 8'h10 | c[7:0]);
      for (int j = 0; j < 6; j++)
      begin
        est = (j == 0) ? 16'sh7fff : $random(seed);
        bw = $random(seed) & 16'h7fff;
        tick(1);
        chk(comp, exp_clamp(est, bw, c[1:0]));
      end
    end
    $display("test clamp done");
    wr(6'h19, 8'h26);
    rs = 1;
    tick(1);
    rs = 0;
    tick(1);
    chk(frz, 1);
    chk(crf, 1);
    h = comp;
    est = ~comp;
    tick(2);
    chk(comp, h);
    cs = 1;
    tick(1);
    chk(frz, 0);
    sy = 1;
    tick(1);
    sy = 0;
    chk(gain, exp_gain(8'h26, 1));
    wr(6'h19, 8'h22);
    tick(1);
    chk(gain, exp_gain(8'h22, 1));
    wr(6'h19, 8'h26);
    cs = 0;
    rs = 1;
    tick(1);
    rs = 0;
    chk(frz, 1);
    chk(gain, exp_gain(8'h26, 0));
    $display("test loop done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
